/* File: usb_host_port_status_regs.sv */
// Purpose: Operational registers for the context array pointer, slot
//          count and per-port status and control of a USB host controller.
// Assumes: Single 10 MHz clock; word-wide register accesses only.
// Notes:   reset_n is the power-on reset; globalResetIn is the global
//          reset pin; hcReset is the ordinary controller reset.
//          Sticky port state ignores hcReset on purpose.
//
// Contract
// - Context pointer bits 31:6, low bits zero
// - Slot count byte at 38h, resets zero
// - One port register per port, 400h stride 10h
// - Port register resets to 2A0h, plus bit30 on removable ports
// - Warm-reset bits live only on USB3 ports
// - Bit 30 reads the inverse of the per-port non-removable setting
// - Wake enables for overcurrent, disconnect, connect
// - Change flags 23..17 set by events, write-one-clear
// - Link strobe bit 16 always reads zero
// - Indicator field stored, drives nothing
// - Sticky bits cleared only by global/power-on reset
// - Reserved bits ignore writes, read zero
`default_nettype none

module usb_host_port_status_regs
    import usb_port_regs_pkg::*;
#(
    parameter int unsigned             NUM_PORTS      = 4,
    parameter logic [NUM_PORTS-1:0]    USB3_PORT_MASK = {NUM_PORTS{1'b1}}
) (
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    input  wire logic                   globalResetIn,
    input  wire logic                   hcReset,
    input  wire logic [11:0]            regAddr,
    input  wire logic                   regWrite,
    input  wire logic                   regRead,
    input  wire logic [31:0]            regWdata,
    output var  logic [31:0]            regRdata,
    output var  logic                   regReadValid,
    input  wire logic [NUM_PORTS-1:0]   connectedNow,
    input  wire logic [NUM_PORTS-1:0]   overcurrentPin,
    input  wire logic [NUM_PORTS*4-1:0] linkStateIn,
    input  wire logic [NUM_PORTS-1:0]   linkStateEvent,
    input  wire logic [NUM_PORTS-1:0]   configErrorEvent,
    input  wire logic [NUM_PORTS-1:0]   portDisableEvent,
    input  wire logic [NUM_PORTS-1:0]   portResetDone,
    input  wire logic [NUM_PORTS-1:0]   warmResetDone,
    input  wire logic [NUM_PORTS*4-1:0] portSpeedIn,
    input  wire logic [NUM_PORTS-1:0]   nonremovableCfg,
    output var  logic [31:0]            contextArrayPtr,
    output var  logic [7:0]             slotsEnabled,
    output var  logic [NUM_PORTS-1:0]   portPowerOn,
    output var  logic [NUM_PORTS-1:0]   portResetReq,
    output var  logic [NUM_PORTS-1:0]   warmResetReq,
    output var  logic [NUM_PORTS-1:0]   linkStateWrite,
    output var  logic [NUM_PORTS*4-1:0] linkStateTarget,
    output var  logic [NUM_PORTS-1:0]   wakeOvercurrentEn,
    output var  logic [NUM_PORTS-1:0]   wakeDisconnectEn,
    output var  logic [NUM_PORTS-1:0]   wakeConnectEn
);

    // Address match for one port register
    function automatic logic isPortAddr(input logic [11:0] addr,
                                        input int unsigned idx);
        return addr == 12'(PORT_BASE_OFFSET + PORT_STRIDE * idx);
    endfunction : isPortAddr

    logic                    globalClear;
    logic [NUM_PORTS-1:0]    overcurrentNow;
    logic [25:0]             contextPtrField;
    logic [7:0]              slotCount;
    logic [NUM_PORTS-1:0]    portEnabled;
    logic [NUM_PORTS-1:0]    connectedPrev;
    logic [NUM_PORTS-1:0]    overcurrentPrev;
    logic [NUM_PORTS-1:0]    portWrite;
    logic [NUM_PORTS-1:0]    portReadHit;
    logic [NUM_PORTS-1:0][6:0]  changeFlags;
    logic [NUM_PORTS-1:0][1:0]  indicatorCtrl;
    logic [NUM_PORTS-1:0][3:0]  linkState;
    logic [NUM_PORTS-1:0][31:0] portValue;
    logic [31:0]             next_readData;

    // Global reset pin comes from outside the clock domain
    bit_sync #(
        .WIDTH (1)
    ) globalResetSync (
        .clk     (clk),
        .reset_n (reset_n),
        .asyncIn (globalResetIn),
        .syncOut (globalClear)
    );

    // Overcurrent detectors are board pins
    bit_sync #(
        .WIDTH (NUM_PORTS)
    ) overcurrentSync (
        .clk     (clk),
        .reset_n (reset_n),
        .asyncIn (overcurrentPin),
        .syncOut (overcurrentNow)
    );

    // Write decode for the shared registers
    // Misaligned offsets never match, so such writes drop
    wire contextPtrWrite = regWrite && (regAddr == CONTEXT_PTR_OFFSET);
    wire configWrite     = regWrite && (regAddr == CONFIG_OFFSET);

    // Non-sticky registers: ordinary reset clears them too
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            contextPtrField <= CONTEXT_PTR_RESET;
            slotCount       <= SLOT_COUNT_RESET;
        end else if (globalClear || hcReset) begin
            contextPtrField <= CONTEXT_PTR_RESET;
            slotCount       <= SLOT_COUNT_RESET;
        end else begin
            if (contextPtrWrite) begin
                contextPtrField <= regWdata[31:CONTEXT_PTR_LSB];
            end
            if (configWrite) begin
                slotCount <= regWdata[SLOT_COUNT_WIDTH-1:0];
            end
        end
    end

    // Low pointer bits are hardwired zero
    assign contextArrayPtr = {contextPtrField, 6'h00};
    assign slotsEnabled    = slotCount;

    // Previous status levels for change detection, power-on reset only
    // Seeded low, so a port live at power-up flags once
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            connectedPrev   <= '0;
            overcurrentPrev <= '0;
        end else begin
            connectedPrev   <= connectedNow;
            overcurrentPrev <= overcurrentNow;
        end
    end

    // One register set per implemented port
    for (genvar p = 0; p < NUM_PORTS; p++) begin : gPort
        wire        usb3      = USB3_PORT_MASK[p];
        wire        wr        = portWrite[p];
        wire [31:0] wd        = regWdata;
        wire        strobeWr  = wr && wd[LINK_STROBE_BIT];
        wire [3:0]  linkIn    = linkStateIn[p*4 +: 4];
        wire [3:0]  speedIn   = portSpeedIn[p*4 +: 4];

        // Reset completion, a start in the same cycle wins
        // A done pulse with nothing pending is ignored
        wire resetFinish = portResetReq[p] && portResetDone[p];
        wire warmFinish  = usb3 && warmResetReq[p] && warmResetDone[p];
        wire next_reset  = (portResetReq[p] && !portResetDone[p])
                           || (wr && wd[PORT_RESET_BIT]);
        wire next_warm   = usb3 && ((warmResetReq[p] && !warmResetDone[p])
                           || (wr && wd[WARM_RESET_BIT]));

        // Enable comes up after a reset, drops on error or disconnect
        // Disconnect drops enable silently; only a disable event flags it
        wire disableHit  = portEnabled[p] && portDisableEvent[p];
        wire next_enable = (portEnabled[p] && !(wr && wd[ENABLED_BIT])
                           && !portDisableEvent[p] && connectedNow[p])
                           || resetFinish || warmFinish;

        // Event sources for the change group
        wire [6:0] chgSet;
        assign chgSet[CHG_CONFIG_ERR] = usb3 && configErrorEvent[p];
        assign chgSet[CHG_LINK]       = linkStateEvent[p];
        assign chgSet[CHG_RESET]      = resetFinish;
        assign chgSet[CHG_OVC]        = overcurrentNow[p] ^ overcurrentPrev[p];
        assign chgSet[CHG_WARM]       = warmFinish;
        assign chgSet[CHG_ENABLE]     = disableHit;
        assign chgSet[CHG_CONNECT]    = connectedNow[p] ^ connectedPrev[p];

        // Write one clears; a new event in the same cycle survives
        wire [6:0] chgClr   = wr ? wd[CHG_MSB:CHG_LSB] : 7'h00;
        wire [6:0] next_chg = (changeFlags[p] & ~chgClr) | chgSet;

        // Link report from the port overrides a software request
        // so the register never shows a state the link has left
        wire [3:0] next_link = linkStateEvent[p] ? linkIn
                             : strobeWr ? wd[LINK_STATE_LSB +: 4]
                             : linkState[p];

        // Sticky state: only power-on or global reset clears it
        // Controller reset left out so wake setup survives it
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                portPowerOn[p]       <= PORT_RESET_VALUE[POWER_BIT];
                linkState[p]         <= LINK_STATE_RESET;
                portResetReq[p]      <= 1'b0;
                warmResetReq[p]      <= 1'b0;
                portEnabled[p]       <= 1'b0;
                changeFlags[p]       <= CHG_RESET_VALUE;
                indicatorCtrl[p]     <= INDICATOR_RESET;
                wakeOvercurrentEn[p] <= WAKE_RESET[2];
                wakeDisconnectEn[p]  <= WAKE_RESET[1];
                wakeConnectEn[p]     <= WAKE_RESET[0];
            end else if (globalClear) begin
                portPowerOn[p]       <= PORT_RESET_VALUE[POWER_BIT];
                linkState[p]         <= LINK_STATE_RESET;
                portResetReq[p]      <= 1'b0;
                warmResetReq[p]      <= 1'b0;
                portEnabled[p]       <= 1'b0;
                changeFlags[p]       <= CHG_RESET_VALUE;
                indicatorCtrl[p]     <= INDICATOR_RESET;
                wakeOvercurrentEn[p] <= WAKE_RESET[2];
                wakeDisconnectEn[p]  <= WAKE_RESET[1];
                wakeConnectEn[p]     <= WAKE_RESET[0];
            end else begin
                portResetReq[p]  <= next_reset;
                warmResetReq[p]  <= next_warm;
                portEnabled[p]   <= next_enable;
                changeFlags[p]   <= next_chg;
                linkState[p]     <= next_link;
                if (wr) begin
                    portPowerOn[p]       <= wd[POWER_BIT];
                    indicatorCtrl[p]     <= wd[INDICATOR_LSB +: 2];
                    wakeOvercurrentEn[p] <= wd[WAKE_OVC_BIT];
                    wakeDisconnectEn[p]  <= wd[WAKE_DISC_BIT];
                    wakeConnectEn[p]     <= wd[WAKE_CONN_BIT];
                end
            end
        end

        // Request to the link logic, one pulse per strobed write
        // Target holds its last value so the link can re-read it
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                linkStateWrite[p]        <= 1'b0;
                linkStateTarget[p*4 +: 4] <= LINK_STATE_RESET;
            end else begin
                linkStateWrite[p] <= strobeWr;
                if (strobeWr) begin
                    linkStateTarget[p*4 +: 4] <= wd[LINK_STATE_LSB +: 4];
                end
            end
        end

        // Read image; reserved bits and the strobe stay zero
        // Live inputs pass through unregistered, same-clock levels, except overcurrent, which comes from the two-stage synchroniser
        assign portValue[p] = {
            warmResetReq[p],
            nonremovableCfg[p] ? 1'b0 : 1'b1,
            2'b00,
            wakeOvercurrentEn[p],
            wakeDisconnectEn[p],
            wakeConnectEn[p],
            1'b0,
            changeFlags[p],
            1'b0,
            indicatorCtrl[p],
            speedIn,
            portPowerOn[p],
            linkState[p],
            portResetReq[p],
            overcurrentNow[p],
            1'b0,
            portEnabled[p],
            connectedNow[p]
        };

        // Address decode per port
        // Offsets past the last port decode to nothing
        assign portWrite[p]   = regWrite && isPortAddr(regAddr, p);
        assign portReadHit[p] = isPortAddr(regAddr, p);
    end : gPort

    // Read selection; unmapped addresses return zero
    // Ports never alias the shared offsets, so order is free
    always_comb begin
        next_readData = 32'h0000_0000;
        if (regAddr == CONTEXT_PTR_OFFSET) begin
            next_readData = {contextPtrField, 6'h00};
        end else if (regAddr == CONFIG_OFFSET) begin
            next_readData = {24'h00_0000, slotCount};
        end
        for (int i = 0; i < NUM_PORTS; i++) begin
            if (portReadHit[i]) begin
                next_readData = portValue[i];
            end
        end
    end

    // Read data registered, valid the cycle after the request
    // A cycle of latency keeps the decode off the bus path
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            regRdata     <= 32'h0000_0000;
            regReadValid <= 1'b0;
        end else begin
            regReadValid <= regRead;
            if (regRead) begin
                regRdata <= next_readData;
            end
        end
    end

endmodule : usb_host_port_status_regs

`default_nettype wire

/* File: usb_port_regs_pkg.sv */
// Purpose: Shared offsets, field positions and reset values for the
//          port status register bank.
// Assumes: Byte addresses relative to the operational register base.
// Notes:   Every field position used by more than one place lives here.
`default_nettype none

package usb_port_regs_pkg;

    // Register offsets
    localparam logic [11:0] CONTEXT_PTR_OFFSET = 12'h030;
    localparam logic [11:0] CONFIG_OFFSET      = 12'h038;
    localparam logic [11:0] PORT_BASE_OFFSET   = 12'h400;
    localparam logic [11:0] PORT_STRIDE        = 12'h010;

    // Context array pointer field
    localparam int unsigned CONTEXT_PTR_LSB = 6;

    // Slot count field width
    localparam int unsigned SLOT_COUNT_WIDTH = 8;

    // Port status field positions
    localparam int unsigned WARM_RESET_BIT     = 31;
    localparam int unsigned REMOVABLE_BIT      = 30;
    localparam int unsigned WAKE_OVC_BIT       = 27;
    localparam int unsigned WAKE_DISC_BIT      = 26;
    localparam int unsigned WAKE_CONN_BIT      = 25;
    localparam int unsigned CHG_MSB            = 23;
    localparam int unsigned CHG_LSB            = 17;
    localparam int unsigned LINK_STROBE_BIT    = 16;
    localparam int unsigned INDICATOR_LSB      = 14;
    localparam int unsigned SPEED_LSB          = 10;
    localparam int unsigned POWER_BIT          = 9;
    localparam int unsigned LINK_STATE_LSB     = 5;
    localparam int unsigned PORT_RESET_BIT     = 4;
    localparam int unsigned OVERCURRENT_BIT    = 3;
    localparam int unsigned ENABLED_BIT        = 1;
    localparam int unsigned CONNECTED_BIT      = 0;

    // Change flag order inside the seven-bit change group, high to low
    localparam int unsigned CHG_CONFIG_ERR = 6;
    localparam int unsigned CHG_LINK       = 5;
    localparam int unsigned CHG_RESET      = 4;
    localparam int unsigned CHG_OVC        = 3;
    localparam int unsigned CHG_WARM       = 2;
    localparam int unsigned CHG_ENABLE     = 1;
    localparam int unsigned CHG_CONNECT    = 0;

    // Reset values
    localparam logic [31:0] PORT_RESET_VALUE   = 32'h0000_02A0;
    localparam logic [3:0]  LINK_STATE_RESET   = 4'h5;
    localparam logic [7:0]  SLOT_COUNT_RESET   = 8'h00;
    localparam logic [25:0] CONTEXT_PTR_RESET  = 26'h000_0000;
    localparam logic [1:0]  INDICATOR_RESET    = 2'h0;
    localparam logic [2:0]  WAKE_RESET         = 3'h0;
    localparam logic [6:0]  CHG_RESET_VALUE    = 7'h00;

endpackage : usb_port_regs_pkg

`default_nettype wire

/* File: bit_sync.sv */
// Purpose: Two flip-flop synchroniser for asynchronous level inputs.
// Assumes: Each bit is an independent slow level.
// Notes:   The first stage feeds only the second stage.
`default_nettype none

module bit_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] asyncIn,
    output var  logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] firstStage;

    // Two stages to let metastability settle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            firstStage <= '0;
            syncOut    <= '0;
        end else begin
            firstStage <= asyncIn;
            syncOut    <= firstStage;
        end
    end

endmodule : bit_sync

`default_nettype wire

/* File: usb_host_port_status_regs_sva.sv */
// Purpose: Bus, port-one and last-port USB2 relations of the port status register bank.
// Assumes: Single clock; reset_n is the only asynchronous reset.
// Notes:   Port one is watched for strobe and reset handshakes.
`default_nettype none

module usb_host_port_status_regs_sva
    import usb_port_regs_pkg::*;
#(
    parameter int unsigned          NUM_PORTS      = 4,
    parameter logic [NUM_PORTS-1:0] USB3_PORT_MASK = {NUM_PORTS{1'b1}}
) (
    input wire logic                   clk,
    input wire logic                   reset_n,
    input wire logic                   globalResetIn,
    input wire logic [11:0]            regAddr,
    input wire logic                   regWrite,
    input wire logic                   regRead,
    input wire logic [31:0]            regWdata,
    input wire logic [31:0]            regRdata,
    input wire logic                   regReadValid,
    input wire logic [NUM_PORTS-1:0]   linkStateEvent,
    input wire logic [NUM_PORTS-1:0]   portResetDone,
    input wire logic [NUM_PORTS-1:0]   portResetReq,
    input wire logic [NUM_PORTS-1:0]   warmResetReq,
    input wire logic [NUM_PORTS-1:0]   linkStateWrite,
    input wire logic [NUM_PORTS*4-1:0] linkStateTarget
);
    // Decodes used by one or more properties
    wire logic isPort   = (regAddr[11:6] == 6'h10) && (regAddr[3:0] == 4'h0);
    wire logic wrPort1  = regWrite && (regAddr == PORT_BASE_OFFSET);
    wire logic strobeWr = wrPort1 && regWdata[16];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    AST_READ_VALID: assert property (regRead |=> regReadValid)
        else $error("read not answered next cycle");
    AST_VALID_CAUSE: assert property (regReadValid |-> $past(regRead))
        else $error("read valid without a read");
    AST_PTR_READ: assert property (regRead && regAddr == CONTEXT_PTR_OFFSET |=>
        regRdata[5:0] == 6'h00) else $error("pointer low bits not zero");
    AST_CFG_READ: assert property (regRead && regAddr == CONFIG_OFFSET |=>
        regRdata[31:8] == 24'h000000) else $error("slot count upper bits not zero");
    AST_PORT_RSVD: assert property (regRead && isPort |=> regRdata[29:28] == 2'b00
        && !regRdata[24] && !regRdata[16] && !regRdata[2]) else $error("port reserved bit set");
    AST_STROBE_PULSE: assert property (strobeWr && !linkStateEvent[0] |=>
        linkStateWrite[0] && linkStateTarget[3:0] == $past(regWdata[8:5]))
        else $error("strobed link write not passed on");
    AST_STROBE_ONLY: assert property (linkStateWrite[0] |-> $past(strobeWr))
        else $error("link write without strobe");
    AST_RESET_REQ: assert property (wrPort1 && regWdata[4] |=> portResetReq[0])
        else $error("port reset not started");
    AST_RESET_HOLD: assert property (portResetReq[0] && !portResetDone[0] &&
        !globalResetIn && !$past(globalResetIn) |=> portResetReq[0])
        else $error("port reset dropped early");
    AST_WARM_USB2: assert property (!USB3_PORT_MASK[NUM_PORTS-1] |->
        !warmResetReq[NUM_PORTS-1]) else $error("warm reset on a USB2 port");

    // Main scenarios reached
    COV_READ: cover property (regRead ##1 regReadValid);
    COV_STROBE: cover property (strobeWr ##1 linkStateWrite[0]);
    COV_RESET: cover property (portResetReq[0] ##1 !portResetReq[0]);
endmodule : usb_host_port_status_regs_sva

bind usb_host_port_status_regs usb_host_port_status_regs_sva #(
    .NUM_PORTS(NUM_PORTS), .USB3_PORT_MASK(USB3_PORT_MASK)
) usb_host_port_status_regs_sva_i (
    .clk(clk), .reset_n(reset_n), .globalResetIn(globalResetIn), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
    .regReadValid(regReadValid), .linkStateEvent(linkStateEvent),
    .portResetDone(portResetDone), .portResetReq(portResetReq), .warmResetReq(warmResetReq),
    .linkStateWrite(linkStateWrite), .linkStateTarget(linkStateTarget)
);

`default_nettype wire

/* File: usb_host_port_status_regs_tb.sv */
// Purpose: Self-checking bench for the port status register bank.
// Assumes: Port four is a USB2 port; port four is fixed non-removable.
// Notes:   Each task drives one scenario and judges its reads.
`default_nettype none

module usb_host_port_status_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, reset_n, globalResetIn, hcReset, regWrite, regRead, regReadValid;
    logic [11:0] regAddr;
    logic [31:0] regWdata, regRdata, contextArrayPtr;
    logic [7:0]  slotsEnabled;
    logic [3:0]  connectedNow, overcurrentPin, linkStateEvent, configErrorEvent;
    logic [3:0]  portDisableEvent, portResetDone, warmResetDone, nonremovableCfg;
    logic [3:0]  portPowerOn, portResetReq, warmResetReq, linkStateWrite;
    logic [3:0]  wakeOvercurrentEn, wakeDisconnectEn, wakeConnectEn;
    logic [15:0] linkStateIn, portSpeedIn, linkStateTarget;
    int          error_cnt = 0;
    int          checks = 0;

    usb_host_port_status_regs #(.NUM_PORTS(4), .USB3_PORT_MASK(4'b0111))
        usb_host_port_status_regs_i (
        .clk(clk), .reset_n(reset_n), .globalResetIn(globalResetIn), .hcReset(hcReset),
        .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
        .regRdata(regRdata), .regReadValid(regReadValid), .connectedNow(connectedNow),
        .overcurrentPin(overcurrentPin), .linkStateIn(linkStateIn),
        .linkStateEvent(linkStateEvent), .configErrorEvent(configErrorEvent),
        .portDisableEvent(portDisableEvent), .portResetDone(portResetDone),
        .warmResetDone(warmResetDone), .portSpeedIn(portSpeedIn),
        .nonremovableCfg(nonremovableCfg), .contextArrayPtr(contextArrayPtr),
        .slotsEnabled(slotsEnabled), .portPowerOn(portPowerOn), .portResetReq(portResetReq),
        .warmResetReq(warmResetReq), .linkStateWrite(linkStateWrite),
        .linkStateTarget(linkStateTarget), .wakeOvercurrentEn(wakeOvercurrentEn),
        .wakeDisconnectEn(wakeDisconnectEn), .wakeConnectEn(wakeConnectEn)
    );

    // 100 ns clock
    always #50 clk = ~clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
        #1;
    endtask : wr

    // Masked read; valid is judged in the cycle after the taking edge
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        chk({31'h0, regReadValid}, 32'h1);
        chk(regRdata & m, exp & m);
    endtask : rd

    task automatic reset_values;
        rd(12'h030, 32'h0, '1);
        rd(12'h038, 32'h0, '1);
        rd(12'h400, 32'h4000_02A0, '1);
        rd(12'h430, 32'h0000_02A0, '1);
        chk({28'h0, portPowerOn}, 32'hF);
        rd(12'h0FC, 32'h0, '1);
    endtask : reset_values

    task automatic pointer_and_slots;
        wr(12'h030, 32'hFFFF_FFFF);
        rd(12'h030, 32'hFFFF_FFC0, '1);
        chk(contextArrayPtr, 32'hFFFF_FFC0);
        wr(12'h038, 32'hFFFF_FFFF);
        rd(12'h038, 32'h0000_00FF, '1);
        chk({24'h0, slotsEnabled}, 32'hFF);
    endtask : pointer_and_slots

    // Link field written without strobe must not move
    task automatic plain_fields;
        wr(12'h410, 32'h3F00_C3E4);
        rd(12'h410, 32'h4E00_C2A0, '1);
        chk({29'h0, wakeOvercurrentEn[1], wakeDisconnectEn[1], wakeConnectEn[1]}, 32'h7);
    endtask : plain_fields

    task automatic link_write;
        wr(12'h400, 32'h0001_0260);
        chk({31'h0, linkStateWrite[0]}, 32'h1);
        rd(12'h400, 32'h4000_0260, '1);
        chk({28'h0, linkStateTarget[3:0]}, 32'h3);
    endtask : link_write

    task automatic port_reset;
        @(posedge clk) connectedNow[0] <= 1'b1;
        wr(12'h400, 32'h0000_0210);
        chk({31'h0, portResetReq[0]}, 32'h1);
        rd(12'h400, 32'h4002_0211, 32'hFFFF_FE1F);
        @(posedge clk) portResetDone[0] <= 1'b1;
        @(posedge clk) portResetDone[0] <= 1'b0;
        rd(12'h400, 32'h4022_0203, 32'hFFFF_FE1F);
        chk({31'h0, portResetReq[0]}, 32'h0);
        wr(12'h400, 32'h00FE_0200);
        rd(12'h400, 32'h4000_0203, 32'hFFFF_FE1F);
        @(posedge clk) portDisableEvent[0] <= 1'b1;
        @(posedge clk) portDisableEvent[0] <= 1'b0;
        rd(12'h400, 32'h4004_0201, 32'hFFFF_FE1F);
        wr(12'h400, 32'h0004_0200);
        rd(12'h400, 32'h4000_0201, 32'hFFFF_FE1F);
    endtask : port_reset

    // Port four is USB2, so its warm and config bits stay reserved
    task automatic warm_reset;
        wr(12'h400, 32'h8000_0200);
        chk({31'h0, warmResetReq[0]}, 32'h1);
        @(posedge clk) warmResetDone[0] <= 1'b1;
        configErrorEvent <= 4'b1001;
        @(posedge clk) warmResetDone[0] <= 1'b0;
        configErrorEvent <= 4'b0000;
        rd(12'h400, 32'h4088_0203, 32'hFFFF_FE1F);
        wr(12'h430, 32'h8088_0200);
        chk({31'h0, warmResetReq[3]}, 32'h0);
        rd(12'h430, 32'h0000_02A0, '1);
    endtask : warm_reset

    task automatic port_events;
        @(posedge clk) overcurrentPin[2] <= 1'b1;
        linkStateIn[11:8] <= 4'h7;
        repeat (4) @(posedge clk);
        linkStateEvent[2] <= 1'b1;
        @(posedge clk) linkStateEvent[2] <= 1'b0;
        rd(12'h420, 32'h4050_02E8, '1);
    endtask : port_events

    // Ordinary reset keeps sticky bits, global reset clears them
    task automatic sticky_bits;
        @(posedge clk) hcReset <= 1'b1;
        @(posedge clk) hcReset <= 1'b0;
        rd(12'h030, 32'h0, '1);
        rd(12'h038, 32'h0, '1);
        rd(12'h410, 32'h4E00_C2A0, '1);
        @(posedge clk) globalResetIn <= 1'b1;
        repeat (4) @(posedge clk);
        globalResetIn <= 1'b0;
        repeat (4) @(posedge clk);
        rd(12'h410, 32'h4000_02A0, '1);
        chk({31'h0, wakeConnectEn[1]}, 32'h0);
    endtask : sticky_bits

    task automatic print_verdict;
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : print_verdict

    // Generous bound; the sequence needs about a hundred cycles
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        print_verdict();
    end

    // Main sequence
    initial begin
        clk = 0; reset_n = 0; globalResetIn = 0; hcReset = 0; regAddr = '0; regWrite = 0;
        regRead = 0; regWdata = '0; connectedNow = '0; overcurrentPin = '0; linkStateIn = '0;
        linkStateEvent = '0; configErrorEvent = '0; portDisableEvent = '0; portResetDone = '0;
        warmResetDone = '0; portSpeedIn = '0; nonremovableCfg = 4'b1000;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        reset_values();
        pointer_and_slots();
        plain_fields();
        link_write();
        port_reset();
        warm_reset();
        port_events();
        sticky_bits();
        print_verdict();
    end
endmodule : usb_host_port_status_regs_tb

`default_nettype wire
